// >>> clk_gate_pkg.sv
// constants for the sleep-mode unit clock gating block
// assumes a 32-bit apb slave decoding a 12-bit offset
package clk_gate_pkg;

    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [11:0] RUN_CFG_OFS = 12'h060;
    localparam logic [11:0] RUN_GATE_OFS = 12'h100;
    localparam logic [11:0] SLEEP_GATE_OFS = 12'h110;
    localparam logic [11:0] DEEP_GATE_OFS = 12'h120;
    localparam logic [11:0] INT_STAT_OFS = 12'h130;
    localparam logic [11:0] INT_MASK_OFS = 12'h134;
    localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;

    // -----------------------------------------------------------------
    // field layout
    // -----------------------------------------------------------------
    localparam int CONV_BIT = 16;
    localparam int KEEPER_BIT = 6;
    localparam int WDOG_BIT = 3;
    localparam int RATE_LO = 8;
    localparam int RATE_W = 4;
    localparam int ACG_BIT = 0;
    localparam int NUM_UNITS = 3;
    localparam logic [31:0] GATE_WMASK = 32'h00010F48;
    localparam logic [31:0] CFG_WMASK = 32'h00000001;

    // unit index order on UNIT_* ports: converter, keeper, watchdog
    localparam logic [NUM_UNITS-1:0] FAULT_CAPABLE = 3'h5;

    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [31:0] RUN_GATE_RST = 32'h00000040;
    localparam logic [31:0] SLEEP_GATE_RST = 32'h00000040;
    localparam logic [31:0] DEEP_GATE_RST = 32'h00000040;
    localparam logic [31:0] CFG_RST = 32'h00000000;

    // -----------------------------------------------------------------
    // sample rate codes
    // -----------------------------------------------------------------
    localparam logic [3:0] RATE_1M = 4'h3;
    localparam logic [3:0] RATE_500K = 4'h2;
    localparam logic [3:0] RATE_250K = 4'h1;
    localparam logic [3:0] RATE_125K = 4'h0;

    // interrupt status bits
    localparam int EV_CONV_FAULT = 0;
    localparam int EV_WDOG_FAULT = 1;
    localparam int EV_MODE_CHG = 2;
    localparam int NUM_EV = 3;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP
    } pwr_mode_t;

endpackage : clk_gate_pkg

// >>> clk_gate.sv
// unit clock gating for converter, low power keeper and watchdog
// assumes an apb master, a power sequencer giving sleep levels and
// unit access strobes from the peripheral bus decoder
//
// The APB slave port was decided locally.
`timescale 1ns/1ps

// What this block does
// - a set gating bit clocks its unit, a clear bit leaves it stopped.
// - an access to the converter or watchdog whose clock is off is answered with a fault.
// - gating bits come up zero after reset, except bit 6 (keeper), which comes up set.
// - separate run, sleep and deep sleep gating registers are kept.
// - sleep and deep sleep registers act only with auto gating set.
// - bit 16 gates the converter, which faults when unclocked.
// - bit 6 gates the low power keeper, with no fault behaviour.
// - bit 3 gates the watchdog, which faults when unclocked.
// - bits 11:8 pick the rate: 3 1M, 2 500K, 1 250K, 0 125K.
// - reserved bits are read only and read as zero.
// - deep sleep register at 0x120, reset value 0x00000040.
// - sleep register decoded at 0x110.
// - run register decoded at 0x100, reset value 0x00000040.
module clk_gate #(
    parameter int ADDR_W = 12
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SLEEP,
    input wire logic DEEP_SLEEP,
    input wire logic [2:0] UNIT_ACC,
    output logic [2:0] UNIT_CLK_EN,
    output logic [2:0] UNIT_FAULT,
    output logic [3:0] CONV_RATE,
    output logic IRQ
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [31:0] run_gate_ff;
    logic [31:0] sleep_gate_ff;
    logic [31:0] deep_gate_ff;
    logic [31:0] cfg_ff;
    logic [2:0] stat_ff;
    logic [2:0] mask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [2:0] clk_en_ff;
    logic [2:0] fault_ff;
    logic [3:0] rate_ff;
    logic irq_ff;
    clk_gate_pkg::pwr_mode_t mode_ff;
    clk_gate_pkg::pwr_mode_t nxt_mode;
    logic [31:0] nxt_rdata;
    logic nxt_err;
    logic [31:0] eff_gate;
    logic [2:0] nxt_clk_en;
    logic [2:0] nxt_fault;
    logic [2:0] ev;
    logic [11:0] ofs;
    logic acc_ph;
    logic done;
    logic wr;

    assign ofs = 12'(PADDR);
    assign acc_ph = PSEL && PENABLE;
    // data phase ends on the edge that sees pready high
    assign done = acc_ph && pready_ff;
    assign wr = done && PWRITE && !pslverr_ff;

    // -----------------------------------------------------------------
    // bus answer
    // -----------------------------------------------------------------
    always_comb begin
        nxt_err = 1'b0;
        case (ofs)
            clk_gate_pkg::RUN_CFG_OFS: nxt_rdata = cfg_ff;
            clk_gate_pkg::RUN_GATE_OFS: nxt_rdata = run_gate_ff;
            clk_gate_pkg::SLEEP_GATE_OFS: nxt_rdata = sleep_gate_ff;
            clk_gate_pkg::DEEP_GATE_OFS: nxt_rdata = deep_gate_ff;
            clk_gate_pkg::INT_STAT_OFS: nxt_rdata = {29'h0, stat_ff};
            clk_gate_pkg::INT_MASK_OFS: nxt_rdata = {29'h0, mask_ff};
            default: begin
                nxt_rdata = 32'h00000000;
                nxt_err = 1'b1;
            end
        endcase
    end

    // one wait state so read data is registered before pready
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else if (CE) begin
            if (acc_ph && !pready_ff) begin
                pready_ff <= 1'b1;
                pslverr_ff <= nxt_err;
                prdata_ff <= PWRITE ? 32'h00000000 : nxt_rdata;
            end else begin
                pready_ff <= 1'b0;
                pslverr_ff <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // gating registers
    // -----------------------------------------------------------------
    // reserved bits never store, so they read back zero
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            run_gate_ff <= clk_gate_pkg::RUN_GATE_RST;
            sleep_gate_ff <= clk_gate_pkg::SLEEP_GATE_RST;
            deep_gate_ff <= clk_gate_pkg::DEEP_GATE_RST;
            cfg_ff <= clk_gate_pkg::CFG_RST;
        end else if (CE && wr) begin
            case (ofs)
                clk_gate_pkg::RUN_GATE_OFS: begin
                    run_gate_ff <= PWDATA
                        & clk_gate_pkg::GATE_WMASK;
                end
                clk_gate_pkg::SLEEP_GATE_OFS: begin
                    sleep_gate_ff <= PWDATA
                        & clk_gate_pkg::GATE_WMASK;
                end
                clk_gate_pkg::DEEP_GATE_OFS: begin
                    deep_gate_ff <= PWDATA
                        & clk_gate_pkg::GATE_WMASK;
                end
                clk_gate_pkg::RUN_CFG_OFS: begin
                    cfg_ff <= PWDATA & clk_gate_pkg::CFG_WMASK;
                end
                default: begin
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // power mode tracking
    // -----------------------------------------------------------------
    always_comb begin
        if (DEEP_SLEEP) begin
            nxt_mode = clk_gate_pkg::MODE_DEEP;
        end else if (SLEEP) begin
            nxt_mode = clk_gate_pkg::MODE_SLEEP;
        end else begin
            nxt_mode = clk_gate_pkg::MODE_RUN;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            mode_ff <= clk_gate_pkg::MODE_RUN;
        end else if (CE) begin
            mode_ff <= nxt_mode;
        end
    end

    // -----------------------------------------------------------------
    // effective gate selection
    // -----------------------------------------------------------------
    always_comb begin
        case (mode_ff)
            clk_gate_pkg::MODE_RUN: eff_gate = run_gate_ff;
            clk_gate_pkg::MODE_SLEEP: begin
                eff_gate = cfg_ff[clk_gate_pkg::ACG_BIT]
                    ? sleep_gate_ff : run_gate_ff;
            end
            clk_gate_pkg::MODE_DEEP: begin
                eff_gate = cfg_ff[clk_gate_pkg::ACG_BIT]
                    ? deep_gate_ff : run_gate_ff;
            end
            default: eff_gate = run_gate_ff;
        endcase
    end

    assign nxt_clk_en = {
        eff_gate[clk_gate_pkg::WDOG_BIT],
        eff_gate[clk_gate_pkg::KEEPER_BIT],
        eff_gate[clk_gate_pkg::CONV_BIT]
    };

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            clk_en_ff <= 3'h0;
            rate_ff <= clk_gate_pkg::RATE_125K;
        end else if (CE) begin
            // bit order already matches the unit index order
            clk_en_ff <= nxt_clk_en;
            // rate code is passed unchanged to the converter
            rate_ff <= eff_gate[clk_gate_pkg::RATE_LO
                +: clk_gate_pkg::RATE_W];
        end
    end

    // -----------------------------------------------------------------
    // unclocked access faults
    // -----------------------------------------------------------------
    // judged against the enable the unit really sees this cycle
    generate
        for (genvar u = 0; u < clk_gate_pkg::NUM_UNITS; u++) begin : g_unit
            assign nxt_fault[u] = UNIT_ACC[u] && !clk_en_ff[u]
                && clk_gate_pkg::FAULT_CAPABLE[u];
        end
    endgenerate

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            fault_ff <= 3'h0;
        end else if (CE) begin
            fault_ff <= nxt_fault;
        end
    end

    // -----------------------------------------------------------------
    // interrupts
    // -----------------------------------------------------------------
    assign ev = {mode_ff != nxt_mode, nxt_fault[2], nxt_fault[0]};

    // set wins over a same-cycle write-one clear
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            stat_ff <= 3'h0;
            mask_ff <= 3'h0;
        end else if (CE) begin
            if (wr && ofs == clk_gate_pkg::INT_STAT_OFS) begin
                stat_ff <= (stat_ff & ~PWDATA[2:0]) | ev;
            end else begin
                stat_ff <= stat_ff | ev;
            end
            if (wr && ofs == clk_gate_pkg::INT_MASK_OFS) begin
                mask_ff <= PWDATA[2:0];
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            irq_ff <= 1'b0;
        end else if (CE) begin
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign UNIT_CLK_EN = {clk_en_ff[2], clk_en_ff[1], clk_en_ff[0]};
    assign UNIT_FAULT = fault_ff;
    assign CONV_RATE = rate_ff;
    assign IRQ = irq_ff;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence s_gate_write(logic [11:0] o);
        wr && ofs == o;
    endsequence

    sequence s_run_mode;
        mode_ff == clk_gate_pkg::MODE_RUN;
    endsequence

    a_reset_gates: assert property (@(posedge CLK_SYS)
        RST |=> run_gate_ff == 32'h00000040
            && deep_gate_ff == 32'h00000040 && clk_en_ff == 3'h0)
        else $error("gating registers wrong after reset");

    a_deep_offset: assert property (@(posedge CLK_SYS)
        disable iff (RST || !CE)
        s_gate_write(12'h120) |=> deep_gate_ff
            == ($past(PWDATA) & 32'h00010F48))
        else $error("deep sleep register not written at 0x120");

    a_sleep_offset: assert property (@(posedge CLK_SYS)
        disable iff (RST || !CE)
        s_gate_write(12'h110) |=> sleep_gate_ff
            == ($past(PWDATA) & 32'h00010F48))
        else $error("sleep register not written at 0x110");

    a_reserved_zero: assert property (@(posedge CLK_SYS)
        disable iff (RST)
        ((run_gate_ff | sleep_gate_ff | deep_gate_ff)
            & 32'hFFFEF0B7) == 32'h0)
        else $error("reserved gating bit is set");

    a_run_select: assert property (@(posedge CLK_SYS)
        disable iff (RST || !CE)
        (s_run_mode or !cfg_ff[0]) ##1 CE |-> clk_en_ff ==
            {$past(run_gate_ff[3]), $past(run_gate_ff[6]),
             $past(run_gate_ff[16])})
        else $error("run register not steering clocks");

    a_deep_select: assert property (@(posedge CLK_SYS)
        disable iff (RST || !CE)
        mode_ff == clk_gate_pkg::MODE_DEEP && cfg_ff[0]
            |=> clk_en_ff[2] == $past(deep_gate_ff[3]))
        else $error("deep sleep watchdog enable wrong");

    a_fault_conv: assert property (@(posedge CLK_SYS)
        disable iff (RST || !CE)
        UNIT_ACC[0] && !clk_en_ff[0] |=> UNIT_FAULT[0])
        else $error("unclocked converter access not faulted");

    a_fault_wdog: assert property (@(posedge CLK_SYS)
        disable iff (RST || !CE)
        UNIT_ACC[2] && clk_en_ff[2] |=> !UNIT_FAULT[2])
        else $error("clocked watchdog access faulted");

    a_fault_wdog_off: assert property (@(posedge CLK_SYS)
        disable iff (RST || !CE)
        UNIT_ACC[2] && !clk_en_ff[2] |=> UNIT_FAULT[2])
        else $error("unclocked watchdog access not faulted");

    a_keeper_nofault: assert property (@(posedge CLK_SYS)
        disable iff (RST)
        !UNIT_FAULT[1])
        else $error("keeper raised a fault");

    a_rate_pass: assert property (@(posedge CLK_SYS)
        disable iff (RST || !CE)
        s_run_mode |=> CONV_RATE == $past(run_gate_ff[11:8]))
        else $error("rate field not passed to converter");

    a_apb_wait: assert property (@(posedge CLK_SYS)
        disable iff (RST || !CE)
        PSEL && !PENABLE ##1 PENABLE |=> PREADY)
        else $error("apb access not answered after one wait");

endmodule : clk_gate

// >>> clk_gate_bench.sv
// self-checking bench for the unit clock gating block
// assumes clk_gate_pkg is compiled first; bench is the only apb master
`timescale 1ns/1ps
module clk_gate_bench;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic CE = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic SLEEP = 1'b0;
    logic DEEP_SLEEP = 1'b0;
    logic [2:0] UNIT_ACC = 3'h0;
    logic [2:0] UNIT_CLK_EN;
    logic [2:0] UNIT_FAULT;
    logic [3:0] CONV_RATE;
    logic IRQ;
    int n_fail = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic er;
    logic [31:0] run_v;
    logic [31:0] slp_v;
    logic [31:0] dp_v;
    logic [11:0] ofs [3];

    always #2 CLK_SYS = ~CLK_SYS;

    clk_gate #(.ADDR_W(12)) i_clk_gate (
        .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SLEEP(SLEEP), .DEEP_SLEEP(DEEP_SLEEP),
        .UNIT_ACC(UNIT_ACC), .UNIT_CLK_EN(UNIT_CLK_EN),
        .UNIT_FAULT(UNIT_FAULT), .CONV_RATE(CONV_RATE), .IRQ(IRQ)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask : cyc

    // pready sampled before this edge's updates land, so no race
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge CLK_SYS);
            if (PREADY === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            end_sim();
        end else begin
            rd = PRDATA;
            er = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, er}, 32'h0);
    endtask : rdchk

    // unit order on ports: converter, keeper, watchdog
    function automatic logic [31:0] en_of(input logic [31:0] r);
        return {29'h0, r[3], r[6], r[16]};
    endfunction : en_of

    // two cycles of lag from mode pins to enables, four allowed
    task automatic mode_chk(input logic s, input logic ds,
                            input logic [31:0] v);
        SLEEP <= s;
        DEEP_SLEEP <= ds;
        cyc(4);
        chk({29'h0, UNIT_CLK_EN}, en_of(v));
        chk({28'h0, CONV_RATE}, {28'h0, v[11:8]});
    endtask : mode_chk

    task automatic acc(input logic [2:0] a, input logic [2:0] e);
        @(posedge CLK_SYS);
        UNIT_ACC <= a;
        @(posedge CLK_SYS);
        UNIT_ACC <= 3'h0;
        @(posedge CLK_SYS);
        chk({29'h0, UNIT_FAULT}, {29'h0, e});
    endtask : acc

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        run_v = 32'h00010348;
        slp_v = 32'h00000208;
        dp_v = 32'h00010100;
        ofs[0] = clk_gate_pkg::RUN_GATE_OFS;
        ofs[1] = clk_gate_pkg::SLEEP_GATE_OFS;
        ofs[2] = clk_gate_pkg::DEEP_GATE_OFS;
        cyc(4);
        RST <= 1'b0;
        cyc(3);
        chk({29'h0, UNIT_CLK_EN}, en_of(32'h40));
        rdchk(ofs[0], 32'h00000040);
        rdchk(ofs[1], 32'h00000040);
        rdchk(ofs[2], 32'h00000040);
        rdchk(clk_gate_pkg::RUN_CFG_OFS, 32'h0);
        $display("test reset values done");
        for (int k = 0; k < 3; k++) begin
            wr(ofs[k], 32'hFFFFFFFF);
            rdchk(ofs[k], 32'h00010F48);
        end
        wr(ofs[0], run_v);
        wr(ofs[1], slp_v);
        wr(ofs[2], dp_v);
        rdchk(ofs[0], run_v);
        rdchk(ofs[1], slp_v);
        rdchk(ofs[2], dp_v);
        mode_chk(1'b0, 1'b0, run_v);
        mode_chk(1'b1, 1'b0, run_v);
        mode_chk(1'b0, 1'b1, run_v);
        wr(clk_gate_pkg::RUN_CFG_OFS, 32'hFFFFFFFF);
        rdchk(clk_gate_pkg::RUN_CFG_OFS, 32'h1);
        mode_chk(1'b1, 1'b0, slp_v);
        mode_chk(1'b1, 1'b1, dp_v);
        mode_chk(1'b0, 1'b0, run_v);
        // enable low must freeze the enables despite a mode request
        CE <= 1'b0;
        SLEEP <= 1'b1;
        cyc(4);
        chk({29'h0, UNIT_CLK_EN}, en_of(run_v));
        CE <= 1'b1;
        mode_chk(1'b1, 1'b0, slp_v);
        mode_chk(1'b0, 1'b0, run_v);
        $display("test modes done");
        for (int k = 0; k < 4; k++) begin
            wr(ofs[0], 32'h00000040 | (32'(k) << 8));
            mode_chk(1'b0, 1'b0, 32'h00000040 | (32'(k) << 8));
        end
        $display("test rate codes done");
        wr(ofs[0], 32'h0);
        wr(clk_gate_pkg::INT_STAT_OFS, 32'h00000007);
        cyc(3);
        rdchk(clk_gate_pkg::INT_STAT_OFS, 32'h0);
        acc(3'h7, 3'h5);
        rdchk(clk_gate_pkg::INT_STAT_OFS, 32'h00000003);
        chk({31'h0, IRQ}, 32'h0);
        wr(clk_gate_pkg::INT_MASK_OFS, 32'h00000001);
        cyc(2);
        chk({31'h0, IRQ}, 32'h1);
        wr(clk_gate_pkg::INT_STAT_OFS, 32'h00000001);
        cyc(2);
        chk({31'h0, IRQ}, 32'h0);
        rdchk(clk_gate_pkg::INT_STAT_OFS, 32'h00000002);
        SLEEP <= 1'b1;
        cyc(4);
        rdchk(clk_gate_pkg::INT_STAT_OFS, 32'h00000006);
        SLEEP <= 1'b0;
        apb(1'b0, ofs[0], 32'h0);
        wr(ofs[0], rd | 32'h00010048);
        cyc(3);
        acc(3'h7, 3'h0);
        $display("test faults and interrupt done");
        apb(1'b0, 12'h200, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h104, 32'hFFFFFFFF);
        chk({31'h0, er}, 32'h1);
        rdchk(ofs[0], 32'h00010048);
        $display("test unmapped done");
        @(posedge CLK_SYS);
        RST <= 1'b1;
        cyc(2);
        RST <= 1'b0;
        cyc(3);
        rdchk(ofs[0], 32'h00000040);
        rdchk(ofs[2], 32'h00000040);
        rdchk(clk_gate_pkg::RUN_CFG_OFS, 32'h0);
        $display("test second reset done");
        end_sim();
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        n_fail++;
        end_sim();
    end
endmodule : clk_gate_bench
